// >>> logic/smbus_clock_buffer_config_consts.vh
// Constants for the SMBus configuration target of the clock buffer
`ifndef SMBUS_CLOCK_BUFFER_CONFIG_CONSTS_VH
`define SMBUS_CLOCK_BUFFER_CONFIG_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_OUTPUT_ENABLE   8'h00
`define OFS_PLL_MODE_AMPL   8'h01
`define OFS_OUTPUT_SLEW     8'h02
`define OFS_FREQ_SELECT     8'h03
`define OFS_RESERVED_ONES   8'h04
`define OFS_REV_VENDOR      8'h05
`define OFS_DEVICE_ID       8'h06
`define OFS_BYTE_COUNT      8'h07

// ----------------------------------------------------------------
// Writable masks, fixed-one bits and reset values
// ----------------------------------------------------------------
`define OE_WR_MASK          8'h6A
`define OE_FIXED_ONES       8'h05
`define OE_RESET            8'h6A
`define PM_WR_MASK          8'h3B
`define PM_FIXED_ONES       8'h04
`define PM_RESET            8'h02
`define SLEW_WR_MASK        8'h6A
`define SLEW_FIXED_ONES     8'h04
`define SLEW_RESET          8'h6A
`define FS_WR_MASK          8'h39
`define FS_FIXED_ONES       8'h82
`define FS_RESET            8'h01
`define RESERVED_VALUE      8'hFF
`define BC_WR_MASK          8'h1F
`define BC_RESET            8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OUT3_BIT            6
`define OUT2_BIT            5
`define OUT1_BIT            3
`define OUT0_BIT            1
`define PLL_SW_EN_BIT       5
`define PLL_SW_SEL_HI       4
`define PLL_SW_SEL_LO       3
`define AMPL_HI             1
`define AMPL_LO             0
`define FREQ_EN_BIT         5
`define FREQ_HI             4
`define FREQ_LO             3
`define FB_SLEW_BIT         0

// ----------------------------------------------------------------
// Target addresses by strap level (00 low, 01 mid, 1x high)
// ----------------------------------------------------------------
`define ADDR_STRAP_LOW      7'h6B
`define ADDR_STRAP_MID      7'h6C
`define ADDR_STRAP_HIGH     7'h6D

// ----------------------------------------------------------------
// Serial engine figures
// ----------------------------------------------------------------
`define BITS_PER_BYTE       4'h8
`define LAST_TX_BIT         4'h7

`endif

// >>> logic/smbus_clock_buffer_config.v
// SMBus configuration target of a four-output clock fanout buffer
`timescale 1ns/10ps
`default_nettype none
`include "smbus_clock_buffer_config_consts.vh"

// Notes on behaviour
// - Write transfer: start plus matching write address is acknowledged.
// - First byte after write address sets the starting offset; acknowledged.
// - Next byte is the data byte count; acknowledged.
// - Data bytes up to the count go to consecutive offsets, each acknowledged.
// - Read: offset written, repeated start, read address; all acknowledged.
// - Read phase returns the byte count first, then registers from offset.
// - Address comes from the select strap, latched once after reset.
// - Byte 0 bits 6,5,3,1 enable outputs, reset 1, override pin.
// - Byte 1 bits 7:6 read back the strapped PLL mode.
// - Byte 1 bit 5 picks strap or bits 4:3 as PLL mode.
// - Byte 1 bits 1:0 pick amplitude 0.6 to 0.9V, reset 10.
// - Byte 2 bits 6,5,3,1 pick slew per output, reset 1.
// - Byte 3 bit 5 gates the frequency select bits 4:3.
// - Byte 3 bit 0 picks feedback slew, reset 1.
// - Offset 4 always reads all ones.
// - Byte 7 holds the writable read byte count, default eight.
module smbus_clock_buffer_config #(
  parameter [7:0] REV_VENDOR_ID = 8'h00,  // Arbitrary value
  parameter [7:0] DEVICE_ID     = 8'h00   // Arbitrary value
) (
  // Clock, reset, enable
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       ce,
  // SMBus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  // Board pins and straps
  input  wire [3:0] out_enable_n_pin,
  input  wire [1:0] addr_select_strap,
  input  wire [1:0] pll_mode_strap,
  // Controls to the clock outputs
  output reg  [3:0] out_enable,
  output reg  [3:0] out_slew_sel,
  output reg        feedback_slew_sel,
  output reg  [1:0] amplitude,
  output reg  [1:0] pll_mode,
  output reg        freq_sel_en,
  output reg  [1:0] freq_choice
);

  // ----------------------------------------------------------------
  // Local encodings
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_RACK = 5'h10;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_OFS  = 2'h1;
  localparam [1:0] PH_CNT  = 2'h2;
  localparam [1:0] PH_DATA = 2'h3;

  localparam       NPIN    = 10;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [1:0]      rst_sync_q;
  wire            rst_n;
  reg  [NPIN-1:0] pin1_q;
  reg  [NPIN-1:0] pin2_q;
  reg  [NPIN-1:0] pin3_q;
  reg  [NPIN-1:0] pin_q;
  reg             scl_prev_q;
  reg             sda_prev_q;
  reg             strap_done_q;
  reg  [6:0]      dev_addr_q;
  reg  [1:0]      pll_strap_q;
  reg  [4:0]      state_q;
  reg  [1:0]      phase_q;
  reg  [3:0]      bit_cnt_q;
  reg  [7:0]      shift_q;
  reg  [7:0]      ptr_q;
  reg  [7:0]      left_q;
  reg             read_q;
  reg             nack_q;
  reg  [7:0]      oe_q;
  reg  [7:0]      pm_q;
  reg  [7:0]      slew_q;
  reg  [7:0]      fs_q;
  reg  [7:0]      bc_q;
  wire [NPIN-1:0] pin_raw;
  wire            scl_s;
  wire            sda_s;
  wire            scl_rise;
  wire            scl_fall;
  wire            start_det;
  wire            stop_det;
  wire [7:0]      count_byte;
  wire [7:0]      rd_next;

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  function [7:0] reg_view;
    input [7:0] ofs;
    begin
      case (ofs)
        `OFS_OUTPUT_ENABLE: reg_view = (oe_q & `OE_WR_MASK) | `OE_FIXED_ONES;
        `OFS_PLL_MODE_AMPL: reg_view = {pll_strap_q, 6'h00}
                                       | (pm_q & `PM_WR_MASK)
                                       | `PM_FIXED_ONES;
        `OFS_OUTPUT_SLEW:   reg_view = (slew_q & `SLEW_WR_MASK)
                                       | `SLEW_FIXED_ONES;
        `OFS_FREQ_SELECT:   reg_view = (fs_q & `FS_WR_MASK) | `FS_FIXED_ONES;
        `OFS_RESERVED_ONES: reg_view = `RESERVED_VALUE;
        `OFS_REV_VENDOR:    reg_view = REV_VENDOR_ID;
        `OFS_DEVICE_ID:     reg_view = DEVICE_ID;
        `OFS_BYTE_COUNT:    reg_view = bc_q & `BC_WR_MASK;
        default:            reg_view = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  assign pin_raw   = {pll_mode_strap, addr_select_strap, out_enable_n_pin,
                      sda_in, scl_in};
  assign scl_s     = pin_q[0];
  assign sda_s     = pin_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign count_byte = bc_q & `BC_WR_MASK;
  assign rd_next   = reg_view(ptr_q);
  // Open drain: the pad only ever pulls low
  assign sda_out   = 1'b0;

  assign rst_n = rst_sync_q[1];

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Serial engine and register file
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_q       <= {NPIN{1'b1}};
      pin2_q       <= {4'h0, 6'h3F};  // Straps wait for real pin data
      pin3_q       <= {NPIN{1'b1}};
      pin_q        <= {NPIN{1'b1}};
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      strap_done_q <= 1'b0;
      dev_addr_q   <= `ADDR_STRAP_LOW;
      pll_strap_q  <= 2'h0;
      state_q      <= ST_IDLE;
      phase_q      <= PH_ADDR;
      bit_cnt_q    <= 4'h0;
      shift_q      <= 8'h00;
      ptr_q        <= 8'h00;
      left_q       <= 8'h00;
      read_q       <= 1'b0;
      nack_q       <= 1'b1;
      sda_oe       <= 1'b0;
      oe_q         <= `OE_RESET;
      pm_q         <= `PM_RESET;
      slew_q       <= `SLEW_RESET;
      fs_q         <= `FS_RESET;
      bc_q         <= `BC_RESET;
    end else if (ce) begin
      pin1_q <= pin_raw;
      pin2_q <= pin1_q;
      pin3_q <= pin2_q;
      // A pin change counts only once two stages agree
      pin_q  <= (pin2_q & pin3_q) | (pin_q & (pin2_q ^ pin3_q));
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      // Straps are caught once the pipe has filled; later moves are ignored
      if (!strap_done_q && (pin2_q[9:6] == pin3_q[9:6])) begin
        strap_done_q <= 1'b1;
        pll_strap_q  <= pin3_q[9:8];
        case (pin3_q[7:6])
          2'h0:    dev_addr_q <= `ADDR_STRAP_LOW;
          2'h1:    dev_addr_q <= `ADDR_STRAP_MID;
          default: dev_addr_q <= `ADDR_STRAP_HIGH;
        endcase
      end
      if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else if (start_det) begin
        // Start and repeated start both restart address reception
        state_q   <= ST_RX;
        phase_q   <= PH_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe    <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
              bit_cnt_q <= 4'h0;
              state_q   <= ST_ACK;
              sda_oe    <= 1'b1;
              case (phase_q)
                PH_ADDR: begin
                  if (shift_q[7:1] == dev_addr_q) begin
                    read_q  <= shift_q[0];
                    phase_q <= PH_OFS;
                  end else begin
                    state_q <= ST_IDLE;
                    sda_oe  <= 1'b0;
                  end
                end
                PH_OFS: begin
                  ptr_q   <= shift_q;
                  phase_q <= PH_CNT;
                end
                PH_CNT: begin
                  left_q  <= shift_q;
                  phase_q <= PH_DATA;
                end
                default: begin
                  // Bytes beyond the announced count are refused
                  if (left_q != 8'h00) begin
                    left_q <= left_q - 8'h01;
                    ptr_q  <= ptr_q + 8'h01;
                    case (ptr_q)
                      `OFS_OUTPUT_ENABLE: oe_q   <= shift_q & `OE_WR_MASK;
                      `OFS_PLL_MODE_AMPL: pm_q   <= shift_q & `PM_WR_MASK;
                      `OFS_OUTPUT_SLEW:   slew_q <= shift_q & `SLEW_WR_MASK;
                      `OFS_FREQ_SELECT:   fs_q   <= shift_q & `FS_WR_MASK;
                      `OFS_BYTE_COUNT:    bc_q   <= shift_q & `BC_WR_MASK;
                      default:            bc_q   <= bc_q;
                    endcase
                  end else begin
                    state_q <= ST_IDLE;
                    sda_oe  <= 1'b0;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (read_q && phase_q == PH_OFS) begin
                // Read address taken: the count byte goes out first
                state_q   <= ST_TX;
                shift_q   <= count_byte;
                sda_oe    <= ~count_byte[7];
                bit_cnt_q <= 4'h0;
              end else begin
                state_q <= ST_RX;
                sda_oe  <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == `LAST_TX_BIT) begin
                state_q <= ST_RACK;
                sda_oe  <= 1'b0;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q   <= {shift_q[6:0], 1'b0};
                sda_oe    <= ~shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                state_q   <= ST_TX;
                shift_q   <= rd_next;
                sda_oe    <= ~rd_next[7];
                ptr_q     <= ptr_q + 8'h01;
                bit_cnt_q <= 4'h0;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_enable        <= 4'h0;
      out_slew_sel      <= 4'hF;
      feedback_slew_sel <= 1'b1;
      amplitude         <= 2'h2;
      pll_mode          <= 2'h0;
      freq_sel_en       <= 1'b0;
      freq_choice       <= 2'h0;
    end else if (ce) begin
      // A cleared bit forces the pair low whatever its pin says
      out_enable   <= {oe_q[`OUT3_BIT], oe_q[`OUT2_BIT],
                       oe_q[`OUT1_BIT], oe_q[`OUT0_BIT]}
                      & ~pin_q[5:2];
      out_slew_sel <= {slew_q[`OUT3_BIT], slew_q[`OUT2_BIT],
                       slew_q[`OUT1_BIT], slew_q[`OUT0_BIT]};
      feedback_slew_sel <= fs_q[`FB_SLEW_BIT];
      amplitude    <= pm_q[`AMPL_HI:`AMPL_LO];
      pll_mode     <= pm_q[`PLL_SW_EN_BIT] ?
                      pm_q[`PLL_SW_SEL_HI:`PLL_SW_SEL_LO] : pll_strap_q;
      freq_sel_en  <= fs_q[`FREQ_EN_BIT];
      freq_choice  <= fs_q[`FREQ_EN_BIT] ?
                      fs_q[`FREQ_HI:`FREQ_LO] : 2'h0;
    end
  end

endmodule
`default_nettype wire

// >>> sim/smbus_config_checker.sv
// Port-level assertions for the SMBus configuration target
`timescale 1ns/10ps
`default_nettype none
module smbus_config_checker (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       ce,
  // Serial bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Board pins
  input wire logic [3:0] out_enable_n_pin,
  input wire logic [1:0] addr_select_strap,
  input wire logic [1:0] pll_mode_strap,
  // Output controls
  input wire logic [3:0] out_enable,
  input wire logic [3:0] out_slew_sel,
  input wire logic       feedback_slew_sel,
  input wire logic [1:0] amplitude,
  input wire logic [1:0] pll_mode,
  input wire logic       freq_sel_en,
  input wire logic [1:0] freq_choice
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------
  sequence s_start; scl_in && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $rose(sda_in); endsequence

  property p_low_only; sda_out == 1'h0; endproperty
  a_low_only: assert property (p_low_only)
    else $error("data driven high");
  property p_edge_low; $changed(sda_oe) |-> !scl_in; endproperty
  a_edge_low: assert property (p_edge_low)
    else $error("data moved with clock high");
  property p_ack_hold; $rose(sda_oe) |-> sda_oe [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low level too short");
  property p_quiet_addr; s_start |=> !sda_oe [*8]; endproperty
  a_quiet_addr: assert property (p_quiet_addr)
    else $error("driven during address");
  property p_release; s_stop |=> !sda_oe [*8]; endproperty
  a_release: assert property (p_release)
    else $error("data held after stop");
  property p_pin_ovr;
    $stable(out_enable_n_pin) [*6] |-> (out_enable & out_enable_n_pin) == 4'h0;
  endproperty
  a_pin_ovr: assert property (p_pin_ovr)
    else $error("enable ignores pin");
  property p_freq_gate; !freq_sel_en |-> freq_choice == 2'h0; endproperty
  a_freq_gate: assert property (p_freq_gate)
    else $error("frequency not gated");
  property p_strap_latch;
    $changed(pll_mode_strap) |=> $stable(pll_mode) [*6];
  endproperty
  a_strap_latch: assert property (p_strap_latch)
    else $error("mode follows live strap");
endmodule
`default_nettype wire

// >>> sim/smbus_host_model.sv
// Behavioural SMBus host issuing block transfers
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial bus
  input wire logic sda_oe,
  output var logic scl,
  output var logic sda_drv
);
  // Pull-up wire: the target can only pull low
  wire logic bus = sda_drv & ~sda_oe;

  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Short hold after the clock falls keeps data off the clock edge
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv = b;
    cyc(10);
    scl = 1'h1;
    cyc(10);
    r = bus;
    scl = 1'h0;
    cyc(4);
  endtask

  task automatic start;
    sda_drv = 1'h1;
    cyc(10);
    scl = 1'h1;
    cyc(10);
    sda_drv = 1'h0;
    cyc(10);
    scl = 1'h0;
    cyc(4);
  endtask

  task automatic stop;
    sda_drv = 1'h0;
    cyc(10);
    scl = 1'h1;
    cyc(10);
    sda_drv = 1'h1;
    cyc(10);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'h1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'h1, d[i]);
    bit_xfer(last, r);
  endtask
endmodule
`default_nettype wire

// >>> sim/smbus_clock_buffer_config_test.sv
// Self-checking testbench for the SMBus configuration target
`timescale 1ns/10ps
`default_nettype none
`include "smbus_clock_buffer_config_consts.vh"
module smbus_clock_buffer_config_test;
  logic       sys_clk   = 1'h0;
  logic       rstn      = 1'h0;
  logic [3:0] pins      = 4'h4;
  logic [1:0] adr_strap = 2'h1;
  logic [1:0] pll_strap = 2'h2;
  logic       ce_en     = 1'h1;
  logic [6:0] dev       = `ADDR_STRAP_MID;
  logic       ack;
  logic [7:0] rd_q [0:8];
  logic [7:0] ex [0:8];
  logic [7:0] wd [0:5];
  int         fails       = 0;
  int         check_count = 0;
  wire logic  scl, sda_drv, sda_out, sda_oe, fb_slew, fs_en;
  wire logic  [3:0] oe, slew;
  wire logic  [1:0] ampl, pmode, fchoice;
  wire logic  sda = sda_drv & ~sda_oe;

  always #10 sys_clk = ~sys_clk;

  // Identity values are arbitrary
  smbus_clock_buffer_config #(.REV_VENDOR_ID(8'h3C), .DEVICE_ID(8'hC3))
  dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce_en), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .out_enable_n_pin(pins),
    .addr_select_strap(adr_strap), .pll_mode_strap(pll_strap),
    .out_enable(oe), .out_slew_sel(slew), .feedback_slew_sel(fb_slew),
    .amplitude(ampl), .pll_mode(pmode), .freq_sel_en(fs_en),
    .freq_choice(fchoice));

  smbus_host_model host_u (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
    .sda_drv(sda_drv));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] cnt, input int n);
    host_u.start();
    host_u.send_byte({dev, 1'h0}, ack);
    check(ack, 1'h1);
    host_u.send_byte(ofs, ack);
    check(ack, 1'h1);
    host_u.send_byte(cnt, ack);
    check(ack, 1'h1);
    for (int i = 0; i < n; i++) begin
      host_u.send_byte(wd[i], ack);
      check(ack, i < cnt);
    end
    host_u.stop();
    host_u.cyc(4);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input int n);
    host_u.start();
    host_u.send_byte({dev, 1'h0}, ack);
    check(ack, 1'h1);
    host_u.send_byte(ofs, ack);
    check(ack, 1'h1);
    host_u.start();
    host_u.send_byte({dev, 1'h1}, ack);
    check(ack, 1'h1);
    for (int i = 0; i <= n; i++) host_u.recv_byte(i == n, rd_q[i]);
    host_u.stop();
    for (int i = 0; i <= n; i++) check(rd_q[i], ex[i]);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check(oe, 4'hB);
    check(slew, 4'hF);
    check({fb_slew, ampl, pmode}, 5'h1A);
    check({fs_en, fchoice}, 3'h0);
    ex = '{8'h08, 8'h6F, 8'h86, 8'h6E, 8'h83, 8'hFF, 8'h3C, 8'hC3, 8'h08};
    rd_chk(8'h00, 8);
  endtask

  task automatic t_write;
    wd = '{8'h15, 8'hF9, 8'h95, 8'h18, 8'h00, 8'h6A};
    wr(8'h00, 8'h05, 6);
    check(oe, 4'h0);
    check({pmode, ampl}, 4'hD);
    check(slew, 4'h0);
    check({fb_slew, fs_en, fchoice}, 4'h0);
    ex = '{8'h08, 8'h05, 8'hBD, 8'h04, 8'h9A, 8'hFF, 8'h0, 8'h0, 8'h0};
    rd_chk(8'h00, 5);
  endtask

  task automatic t_gate;
    wd[0] = 8'h39;
    wr(8'h03, 8'h01, 1);
    check({fb_slew, fs_en, fchoice}, 4'hF);
    for (int a = 0; a < 4; a++) begin
      // Mode bits set while the override stays off
      wd[0] = 8'h18 | a[7:0];
      wr(8'h01, 8'h01, 1);
      check(ampl, a[1:0]);
      check(pmode, 2'h2);
    end
    pll_strap = 2'h1;
    host_u.cyc(10);
    check(pmode, 2'h2);
    ex = '{8'h08, 8'h9F, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    rd_chk(8'h01, 1);
  endtask

  task automatic t_count;
    wd[0] = 8'hE3;
    wr(8'h07, 8'h01, 1);
    ex = '{8'h03, 8'h04, 8'hBB, 8'hFF, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    rd_chk(8'h02, 3);
  endtask

  task automatic t_addr;
    adr_strap = 2'h0;
    host_u.cyc(10);
    host_u.start();
    host_u.send_byte({`ADDR_STRAP_LOW, 1'h0}, ack);
    check(ack, 1'h0);
    host_u.stop();
    ex = '{8'h03, 8'hFF, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    rd_chk(8'h04, 1);
  endtask

  task automatic t_freeze;
    // A frozen target must not answer its own address
    ce_en = 1'h0;
    host_u.start();
    host_u.send_byte({dev, 1'h0}, ack);
    check(ack, 1'h0);
    host_u.stop();
    ce_en = 1'h1;
    host_u.cyc(10);
    wd[0] = 8'h28;
    wr(8'h00, 8'h01, 1);
    check(oe, 4'h2);
    pins = 4'h0;
    host_u.cyc(10);
    check(oe, 4'h6);
    pins = 4'h4;
    host_u.cyc(10);
  endtask

  task automatic t_rerun;
    rstn = 1'h0;
    host_u.cyc(3);
    check({oe, ampl}, 6'h02);
    rstn = 1'h1;
    host_u.cyc(12);
    check({fb_slew, ampl, pmode}, 5'h19);
    check(oe, 4'hB);
    // Straps are caught again after reset: low address now
    dev = `ADDR_STRAP_LOW;
    ex[0] = 8'h08;
    ex[1] = 8'h6F;
    rd_chk(8'h00, 1);
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'h1;
    repeat (12) @(negedge sys_clk);
    t_reset;
    t_write;
    t_gate;
    t_count;
    t_addr;
    t_freeze;
    t_rerun;
    end_of_test;
  end

  // Whole run needs about 19000 cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    end_of_test;
  end
endmodule

bind smbus_clock_buffer_config smbus_config_checker chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .out_enable_n_pin(out_enable_n_pin),
  .addr_select_strap(addr_select_strap), .pll_mode_strap(pll_mode_strap),
  .out_enable(out_enable), .out_slew_sel(out_slew_sel),
  .feedback_slew_sel(feedback_slew_sel), .amplitude(amplitude),
  .pll_mode(pll_mode), .freq_sel_en(freq_sel_en),
  .freq_choice(freq_choice));
`default_nettype wire
